// ---- inc/mgc_map.svh ----
// register offsets, field positions and reset values of the metering register bank
`ifndef MGC_MAP_SVH
`define MGC_MAP_SVH
`define MGC_ADDR_SDIR    8'h0F
`define MGC_ADDR_GAIN    8'h1B
`define MGC_ADDR_CAL     8'h3D
`define MGC_ADDR_ENL     8'hD9
`define MGC_ADDR_ENM     8'hDA
`define MGC_ADDR_STL     8'hDC
`define MGC_ADDR_STM     8'hDD
`define MGC_RST_BYTE     8'h00
`define MGC_RD_NONE      8'h00
`define MGC_GAIN_MASK    8'hEF
`define MGC_SDIR_MASK    8'h70
`define MGC_ENL_MASK     8'h3F
`define MGC_VGAIN_MSB    7
`define MGC_VGAIN_LSB    5
`define MGC_SIGNLOC_BIT  3
`define MGC_IGAIN_MSB    2
`define MGC_IGAIN_LSB    0
`define MGC_ISEL_MSB     5
`define MGC_ISEL_LSB     4
`define MGC_VGND_BIT     3
`define MGC_IGND_BIT     2
`define MGC_ISEL_A       2'h1
`define MGC_ISEL_B       2'h2
`define MGC_DIR_FAULT    6
`define MGC_DIR_REACT    5
`define MGC_DIR_ACT      4
`define MGC_SUM_BIT      7
`define MGC_STL_W        6
`define MGC_STM_W        8
`define MGC_FLAG_W       14
`define MGC_GAIN_MAXCODE 3'h4
`define MGC_GAIN_UNITY   5'h01
`endif

// ---- inc/mgc_pkg.sv ----
// types shared by the metering register bank
package mgc_pkg;
  typedef logic [7:0] mgc_byte_t;
  typedef logic [2:0] mgc_code_t;
  typedef logic [4:0] mgc_gain_t;
  typedef logic [2:0] mgc_trio_t;
endpackage

// ---- inc/mgc_flag_if.sv ----
// interface between the register bank and its sticky flag store
`timescale 1ns/10ps
interface mgc_flag_if #(parameter int N = 14);
  logic [N-1:0] set;
  logic [N-1:0] clr;
  logic [N-1:0] en;
  logic [N-1:0] flags;
  logic         pend;
  modport bank (input set, input clr, input en, output flags, output pend);
  modport ctrl (output set, output clr, output en, input flags, input pend);
endinterface

// ---- logic/mgc_flag_bank.sv ----
// sticky event flags with enable-gated summary
`timescale 1ns/10ps
`include "mgc_map.svh"
module mgc_flag_bank #(
  parameter int N = `MGC_FLAG_W
) (
  input  wire logic clock_i,
  input  wire logic rst_n_i,
  mgc_flag_if.bank  fl
);
  import mgc_pkg::*;

  logic [N-1:0] flags_r;
  logic [N-1:0] flags_nxt;
  logic         pend_r;
  logic         pend_nxt;

  // set beats a clear arriving in the same cycle
  assign flags_nxt = fl.set | (flags_r & ~fl.clr);
  assign pend_nxt  = |(flags_nxt & fl.en);

  always_ff @(posedge clock_i)
  begin
    if (!rst_n_i)
    begin
      flags_r <= '0;
      pend_r  <= 1'b0;
    end
    else
    begin
      flags_r <= flags_nxt;
      pend_r  <= pend_nxt;
    end
  end

  assign fl.flags = flags_r;
  assign fl.pend  = pend_r;
endmodule

// ---- logic/mgc_top.sv ----
// gain, calibration and metering status register bank
//
// The strobed register port was chosen for this implementation.
`timescale 1ns/10ps
`include "mgc_map.svh"
module mgc_top (
  input  wire logic              clock_i,
  input  wire logic              rst_n_i,
  input  wire mgc_pkg::mgc_byte_t addr_i,
  input  wire mgc_pkg::mgc_byte_t wdata_i,
  input  wire logic              wr_i,
  input  wire logic              rd_i,
  output mgc_pkg::mgc_byte_t     rdata_o,
  input  wire logic              act_neg_filt_i,
  input  wire logic              act_neg_pulse_i,
  input  wire logic              react_neg_filt_i,
  input  wire logic              react_neg_pulse_i,
  input  wire logic              fault_mode_i,
  input  wire logic              apparent_noload_evt_i,
  input  wire logic              irms_noload_enter_i,
  input  wire logic              reactive_noload_evt_i,
  input  wire logic              active_noload_evt_i,
  input  wire logic              pulse_out_first_i,
  input  wire logic              pulse_out_second_i,
  input  wire mgc_pkg::mgc_trio_t energy_overflow_i,
  input  wire mgc_pkg::mgc_trio_t energy_half_i,
  input  wire logic              tamper_pick_b_i,
  output mgc_pkg::mgc_gain_t     voltage_gain_o,
  output mgc_pkg::mgc_gain_t     current_gain_o,
  output logic                   sign_detect_location_o,
  output logic                   current_input_b_o,
  output logic                   voltage_input_ground_o,
  output logic                   current_input_ground_o,
  output logic                   metering_irq_summary_o
);
  import mgc_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // helper functions

  // gain factor from a 3-bit code; codes above the largest act as unity
  function automatic mgc_gain_t gain_decode(input mgc_code_t code);
    mgc_gain_t g;
    g = `MGC_GAIN_UNITY;
    if (code <= `MGC_GAIN_MAXCODE)
    begin
      g = mgc_gain_t'(`MGC_GAIN_UNITY << code);
    end
    return g;
  endfunction

  // sign or mode change event in the configured direction
  function automatic logic dir_event(
    input logic prev,
    input logic now,
    input logic dir
  );
    logic ev;
    ev = dir ? (prev & ~now) : (~prev & now);
    return ev;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // register state

  mgc_byte_t gain_r;
  mgc_byte_t gain_nxt;
  mgc_byte_t cal_r;
  mgc_byte_t cal_nxt;
  mgc_byte_t sdir_r;
  mgc_byte_t sdir_nxt;
  mgc_byte_t enl_r;
  mgc_byte_t enl_nxt;
  mgc_byte_t enm_r;
  mgc_byte_t enm_nxt;
  mgc_byte_t rdata_r;
  mgc_byte_t rdata_nxt;
  mgc_gain_t vgain_r;
  mgc_gain_t igain_r;
  logic      cur_b_r;
  logic      cur_b_nxt;
  logic      act_prev_r;
  logic      react_prev_r;
  logic      fault_prev_r;
  logic      primed_r;

  ////////////////////////////////////////////////////////////////////////////
  // address decode

  logic hit_gain;
  logic hit_cal;
  logic hit_sdir;
  logic hit_enl;
  logic hit_enm;
  logic hit_stl;
  logic hit_stm;
  logic wr_gain;
  logic wr_cal;
  logic wr_sdir;
  logic wr_enl;
  logic wr_enm;
  logic wr_stl;
  logic wr_stm;

  assign hit_gain = (addr_i == `MGC_ADDR_GAIN);
  assign hit_cal  = (addr_i == `MGC_ADDR_CAL);
  assign hit_sdir = (addr_i == `MGC_ADDR_SDIR);
  assign hit_enl  = (addr_i == `MGC_ADDR_ENL);
  assign hit_enm  = (addr_i == `MGC_ADDR_ENM);
  assign hit_stl  = (addr_i == `MGC_ADDR_STL);
  assign hit_stm  = (addr_i == `MGC_ADDR_STM);

  assign wr_gain = wr_i & hit_gain;
  assign wr_cal  = wr_i & hit_cal;
  assign wr_sdir = wr_i & hit_sdir;
  assign wr_enl  = wr_i & hit_enl;
  assign wr_enm  = wr_i & hit_enm;
  assign wr_stl  = wr_i & hit_stl;
  assign wr_stm  = wr_i & hit_stm;

  ////////////////////////////////////////////////////////////////////////////
  // writable control registers

  // bit 4 of gain is reserved: never stored
  assign gain_nxt = wr_gain ? (wdata_i & `MGC_GAIN_MASK) : gain_r;
  // full byte kept; reserved bits steer nothing
  assign cal_nxt  = wr_cal ? wdata_i : cal_r;
  assign sdir_nxt = wr_sdir ? (wdata_i & `MGC_SDIR_MASK) : sdir_r;
  assign enl_nxt  = wr_enl ? (wdata_i & `MGC_ENL_MASK) : enl_r;
  assign enm_nxt  = wr_enm ? wdata_i : enm_r;

  always_ff @(posedge clock_i)
  begin
    if (!rst_n_i)
    begin
      gain_r <= `MGC_RST_BYTE;
      cal_r  <= `MGC_RST_BYTE;
      sdir_r <= `MGC_RST_BYTE;
      enl_r  <= `MGC_RST_BYTE;
      enm_r  <= `MGC_RST_BYTE;
    end
    else
    begin
      gain_r <= gain_nxt;
      cal_r  <= cal_nxt;
      sdir_r <= sdir_nxt;
      enl_r  <= enl_nxt;
      enm_r  <= enm_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // analog front end controls

  mgc_code_t vgain_code;
  mgc_code_t igain_code;
  logic      sign_loc;
  logic [1:0] isel;

  assign vgain_code = gain_nxt[`MGC_VGAIN_MSB:`MGC_VGAIN_LSB];
  // a unity current gain is passed on as written
  assign igain_code = gain_nxt[`MGC_IGAIN_MSB:`MGC_IGAIN_LSB];
  assign sign_loc   = gain_r[`MGC_SIGNLOC_BIT];
  assign isel       = cal_r[`MGC_ISEL_MSB:`MGC_ISEL_LSB];

  // forced input A or B, otherwise the tamper logic decides
  assign cur_b_nxt = (isel == `MGC_ISEL_A) ? 1'b0 :
                     (isel == `MGC_ISEL_B) ? 1'b1 :
                     tamper_pick_b_i;

  always_ff @(posedge clock_i)
  begin
    if (!rst_n_i)
    begin
      vgain_r <= `MGC_GAIN_UNITY;
      igain_r <= `MGC_GAIN_UNITY;
      cur_b_r <= 1'b0;
    end
    else
    begin
      vgain_r <= gain_decode(vgain_code);
      igain_r <= gain_decode(igain_code);
      cur_b_r <= cur_b_nxt;
    end
  end

  assign voltage_gain_o         = vgain_r;
  assign current_gain_o         = igain_r;
  assign sign_detect_location_o = gain_r[`MGC_SIGNLOC_BIT];
  assign current_input_b_o      = cur_b_r;
  assign voltage_input_ground_o = cal_r[`MGC_VGND_BIT];
  assign current_input_ground_o = cal_r[`MGC_IGND_BIT];

  ////////////////////////////////////////////////////////////////////////////
  // sign and fault mode change detection

  logic act_neg;
  logic react_neg;
  logic act_evt;
  logic react_evt;
  logic fault_evt;

  // sign source follows the detect location
  assign act_neg   = sign_loc ? act_neg_pulse_i : act_neg_filt_i;
  assign react_neg = sign_loc ? react_neg_pulse_i : react_neg_filt_i;

  // first cycle after reset only samples, so a level present at release is no event
  assign act_evt   = primed_r &
                     dir_event(act_prev_r, act_neg, sdir_r[`MGC_DIR_ACT]);
  assign react_evt = primed_r &
                     dir_event(react_prev_r, react_neg, sdir_r[`MGC_DIR_REACT]);
  // direction 0: entering fault mode, 1: entering normal mode
  assign fault_evt = primed_r &
                     dir_event(fault_prev_r, fault_mode_i, sdir_r[`MGC_DIR_FAULT]);

  always_ff @(posedge clock_i)
  begin
    if (!rst_n_i)
    begin
      act_prev_r   <= 1'b0;
      react_prev_r <= 1'b0;
      fault_prev_r <= 1'b0;
      primed_r     <= 1'b0;
    end
    else
    begin
      act_prev_r   <= act_neg;
      react_prev_r <= react_neg;
      fault_prev_r <= fault_mode_i;
      primed_r     <= 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // event flags

  mgc_flag_if #(.N(`MGC_FLAG_W)) flag_bus ();

  logic [`MGC_STL_W-1:0] low_set;
  logic [`MGC_STM_W-1:0] mid_set;
  logic [`MGC_STL_W-1:0] low_clr;
  logic [`MGC_STM_W-1:0] mid_clr;
  logic [`MGC_STL_W-1:0] low_flags;
  logic [`MGC_STM_W-1:0] mid_flags;

  assign low_set = {fault_evt,
                    react_evt,
                    act_evt,
                    apparent_noload_evt_i | irms_noload_enter_i,
                    reactive_noload_evt_i,
                    active_noload_evt_i};

  // pulse flags set whether or not the pin itself is enabled
  assign mid_set = {pulse_out_second_i,
                    pulse_out_first_i,
                    energy_overflow_i,
                    energy_half_i};

  // writing a zero to a flag clears it, a one leaves it
  assign low_clr = wr_stl ? ~wdata_i[`MGC_STL_W-1:0] : '0;
  assign mid_clr = wr_stm ? ~wdata_i : '0;

  assign flag_bus.set = {mid_set, low_set};
  assign flag_bus.clr = {mid_clr, low_clr};
  assign flag_bus.en  = {enm_r, enl_r[`MGC_STL_W-1:0]};

  assign low_flags = flag_bus.flags[`MGC_STL_W-1:0];
  assign mid_flags = flag_bus.flags[`MGC_FLAG_W-1:`MGC_STL_W];

  mgc_flag_bank #(
    .N (`MGC_FLAG_W)
  ) u_flags (
    .clock_i (clock_i),
    .rst_n_i (rst_n_i),
    .fl      (flag_bus)
  );

  assign metering_irq_summary_o = flag_bus.pend;

  ////////////////////////////////////////////////////////////////////////////
  // read path

  mgc_byte_t stl_view;

  // bit 6 reserved reads zero; summary is read only
  assign stl_view = {flag_bus.pend, 1'b0, low_flags};

  assign rdata_nxt = !rd_i    ? `MGC_RD_NONE :
                     hit_gain ? gain_r :
                     hit_cal  ? cal_r :
                     hit_sdir ? sdir_r :
                     hit_enl  ? enl_r :
                     hit_enm  ? enm_r :
                     hit_stl  ? stl_view :
                     hit_stm  ? mid_flags :
                     `MGC_RD_NONE;

  always_ff @(posedge clock_i)
  begin
    if (!rst_n_i)
    begin
      rdata_r <= `MGC_RD_NONE;
    end
    else
    begin
      rdata_r <= rdata_nxt;
    end
  end

  assign rdata_o = rdata_r;
endmodule

// ---- tb/mgc_monitor.sv ----
// concurrent checks on the register bank ports
`timescale 1ns/10ps
module mgc_monitor (
  input wire logic               clock_i,
  input wire logic               rst_n_i,
  input wire mgc_pkg::mgc_byte_t addr_i,
  input wire mgc_pkg::mgc_byte_t wdata_i,
  input wire logic               wr_i,
  input wire logic               rd_i,
  input wire mgc_pkg::mgc_byte_t rdata_o,
  input wire logic               active_noload_evt_i,
  input wire logic               tamper_pick_b_i,
  input wire mgc_pkg::mgc_gain_t voltage_gain_o,
  input wire logic               current_input_b_o,
  input wire logic               metering_irq_summary_o
);
  import mgc_pkg::*;
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (!rst_n_i);
  wire wr_gain = wr_i && addr_i == 8'h1B;
  wire wr_cal  = wr_i && addr_i == 8'h3D;
  sequence s_gain_back;
    wr_gain ##2 rd_i && addr_i == 8'h1B;
  endsequence
  sequence s_en_evt;
    wr_i && addr_i == 8'hD9 && wdata_i[0] ##1 !wr_i ##1 active_noload_evt_i && !wr_i;
  endsequence
  sequence s_en_off;
    wr_i && addr_i == 8'hD9 && wdata_i == 8'h00 ##2 wr_i && addr_i == 8'hDA && wdata_i == 8'h00;
  endsequence
  chk_rdata_idle: assert property (!rd_i |=> rdata_o == 8'h00)
    else $error("read data not idle");
  chk_gain_back: assert property (s_gain_back |=> rdata_o == ($past(wdata_i, 3) & 8'hEF))
    else $error("gain readback wrong");
  chk_vgain_code: assert property (wr_gain && wdata_i[7:5] <= 3'h4 |=>
    voltage_gain_o == (5'h01 << $past(wdata_i[7:5])))
    else $error("voltage gain decode wrong");
  chk_summary_set: assert property (s_en_evt |=> metering_irq_summary_o)
    else $error("summary not raised");
  chk_summary_off: assert property (s_en_off |=> ##1 !metering_irq_summary_o)
    else $error("summary not cleared");
  chk_isel_auto: assert property (wr_cal && wdata_i[5:4] == 2'h0 ##1 !wr_cal |=>
    current_input_b_o == $past(tamper_pick_b_i))
    else $error("auto input choice wrong");
  chk_isel_force: assert property (wr_cal && wdata_i[5:4] == 2'h1 ##1 !wr_cal |=>
    !current_input_b_o)
    else $error("forced input wrong");
  chk_status_rsvd: assert property (rd_i && addr_i == 8'hDC |=> rdata_o[6] == 1'b0)
    else $error("reserved status bit set");
  chk_noload_held: assert property (active_noload_evt_i ##1 !wr_i ##1 rd_i && addr_i == 8'hDC
    |=> rdata_o[0])
    else $error("noload flag lost");
endmodule
bind mgc_top mgc_monitor u_mon (.clock_i(clock_i), .rst_n_i(rst_n_i), .addr_i(addr_i),
  .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
  .active_noload_evt_i(active_noload_evt_i), .tamper_pick_b_i(tamper_pick_b_i),
  .voltage_gain_o(voltage_gain_o), .current_input_b_o(current_input_b_o),
  .metering_irq_summary_o(metering_irq_summary_o));

// ---- tb/mgc_cpu_model.sv ----
// core-side model that drives the register bus
`timescale 1ns/10ps
module mgc_cpu_model (
  input  wire logic               clock_i,
  input  wire mgc_pkg::mgc_byte_t rdata_i,
  output mgc_pkg::mgc_byte_t      addr_o,
  output mgc_pkg::mgc_byte_t      wdata_o,
  output logic                    wr_o,
  output logic                    rd_o
);
  import mgc_pkg::*;
  initial
  begin
    addr_o = 8'h00;
    wdata_o = 8'h00;
    wr_o = 1'b0;
    rd_o = 1'b0;
  end
  task automatic wr(input mgc_byte_t a, input mgc_byte_t d);
    @(posedge clock_i);
    addr_o <= a;
    wdata_o <= (a == 8'h3D) ? (d & 8'h3C) : d;
    wr_o <= 1'b1;
    @(posedge clock_i);
    wr_o <= 1'b0;
    addr_o <= ~a;
    wdata_o <= ~d;
  endtask
  task automatic rd(input mgc_byte_t a, output mgc_byte_t d);
    @(posedge clock_i);
    addr_o <= a;
    rd_o <= 1'b1;
    @(posedge clock_i);
    rd_o <= 1'b0;
    addr_o <= ~a;
    #1 d = rdata_i;
  endtask
endmodule

// ---- tb/tb.sv ----
// self-checking bench for the metering register bank
`timescale 1ns/10ps
module tb;
  import mgc_pkg::*;
  logic        clock_i = 1'b0;
  logic        rst_n_i = 1'b0;
  logic [14:0] ev = '0;
  logic [1:0]  pls = 2'h0;
  logic        tamper = 1'b0;
  int          error_cnt = 0;
  int          num_checks = 0;
  mgc_byte_t   addr, wdata, rdata;
  mgc_gain_t   vg, ig;
  logic        wr, rd, sdl, ib, vgnd, ignd, irq;
  always #50 clock_i = ~clock_i;
  mgc_cpu_model cpu (.clock_i(clock_i), .rdata_i(rdata), .addr_o(addr), .wdata_o(wdata),
    .wr_o(wr), .rd_o(rd));
  mgc_top dut (.clock_i(clock_i), .rst_n_i(rst_n_i), .addr_i(addr), .wdata_i(wdata),
    .wr_i(wr), .rd_i(rd), .rdata_o(rdata), .act_neg_filt_i(ev[3]), .act_neg_pulse_i(pls[0]),
    .react_neg_filt_i(ev[4]), .react_neg_pulse_i(pls[1]), .fault_mode_i(ev[5]),
    .apparent_noload_evt_i(ev[2]), .irms_noload_enter_i(ev[14]),
    .reactive_noload_evt_i(ev[1]), .active_noload_evt_i(ev[0]),
    .pulse_out_first_i(ev[12]), .pulse_out_second_i(ev[13]),
    .energy_overflow_i(ev[11:9]), .energy_half_i(ev[8:6]), .tamper_pick_b_i(tamper),
    .voltage_gain_o(vg), .current_gain_o(ig), .sign_detect_location_o(sdl),
    .current_input_b_o(ib), .voltage_input_ground_o(vgnd), .current_input_ground_o(ignd),
    .metering_irq_summary_o(irq));
  ////////////////////////////////////////////////////////////////////////////////
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", num_checks, error_cnt);
    if (error_cnt == 0 && num_checks > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  task automatic chk(input mgc_byte_t got, input mgc_byte_t exp);
    num_checks++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic rchk(input mgc_byte_t a, input mgc_byte_t exp);
    mgc_byte_t d;
    cpu.rd(a, d);
    chk(d, exp);
  endtask
  task automatic pulse(input int i);
    @(posedge clock_i);
    ev[i] <= 1'b1;
    @(posedge clock_i);
    ev[i] <= 1'b0;
    #1;
  endtask
  function automatic mgc_byte_t gx(input int c);
    return (c > 4) ? 8'h01 : 8'h01 << c;
  endfunction
  ////////////////////////////////////////////////////////////////////////////////
  task automatic t_reset();
    rchk(8'h1B, 8'h00);
    rchk(8'h3D, 8'h00);
    rchk(8'hDC, 8'h00);
    chk({3'h0, vg}, 8'h01);
    chk({3'h0, ig}, 8'h01);
    $display("test reset done");
  endtask
  task automatic t_gain();
    for (int c = 0; c < 6; c++)
    begin
      cpu.wr(8'h1B, {c[2:0], 1'b1, c[0], 3'(5 - c)});
      #1;
      chk({3'h0, vg}, gx(c));
      chk({3'h0, ig}, gx(5 - c));
      chk({7'h0, sdl}, {7'h0, c[0]});
      rchk(8'h1B, {c[2:0], 1'b0, c[0], 3'(5 - c)});
    end
    // back to filtered sign sources, which the event test drives
    cpu.wr(8'h1B, 8'h00);
    #1;
    chk({7'h0, sdl}, 8'h00);
    $display("test gain done");
  endtask
  task automatic t_cal();
    mgc_byte_t w [4] = '{8'h10, 8'h20, 8'h0C, 8'hF0};
    mgc_byte_t m;
    for (int k = 0; k < 8; k++)
    begin
      m = w[k/2] & 8'h3C;
      @(posedge clock_i);
      tamper <= k[0];
      cpu.wr(8'h3D, w[k/2]);
      repeat (2) @(posedge clock_i);
      #1;
      chk({7'h0, ib}, {7'h0, (m[5:4] == 2'h1) ? 1'b0 : (m[5:4] == 2'h2) ? 1'b1 : k[0]});
      chk({6'h0, vgnd, ignd}, {6'h0, m[3:2]});
      rchk(8'h3D, m);
    end
    $display("test calibration done");
  endtask
  task automatic t_events();
    logic [13:0] f;
    for (int i = 0; i < 15; i++)
    begin
      pulse(i);
      f = 14'h1 << ((i == 14) ? 2 : i);
      cpu.wr(8'hDC, 8'hFF);
      rchk(8'hDC, {2'h0, f[5:0]});
      rchk(8'hDD, f[13:6]);
      cpu.wr(8'hDC, 8'h00);
      cpu.wr(8'hDD, 8'h00);
      rchk(8'hDC, 8'h00);
    end
    $display("test events done");
  endtask
  task automatic t_sign();
    cpu.wr(8'h1B, 8'h08);
    cpu.wr(8'h0F, 8'h10);
    @(posedge clock_i);
    pls <= 2'h1;
    rchk(8'hDC, 8'h00);
    @(posedge clock_i);
    pls <= 2'h2;
    rchk(8'hDC, 8'h18);
    @(posedge clock_i);
    pls <= 2'h0;
    cpu.wr(8'hDC, 8'h00);
    rchk(8'hDC, 8'h00);
    cpu.wr(8'h0F, 8'h00);
    cpu.wr(8'h1B, 8'h00);
    $display("test sign done");
  endtask
  task automatic t_irq();
    pulse(1);
    chk({7'h0, irq}, 8'h00);
    cpu.wr(8'hD9, 8'h01);
    pulse(0);
    chk({7'h0, irq}, 8'h01);
    rchk(8'hDC, 8'h83);
    cpu.wr(8'hDC, 8'hFE);
    #1;
    chk({7'h0, irq}, 8'h00);
    rchk(8'hDC, 8'h02);
    cpu.wr(8'hDA, 8'h80);
    pulse(13);
    chk({7'h0, irq}, 8'h01);
    cpu.wr(8'hD9, 8'h00);
    cpu.wr(8'hDA, 8'h00);
    repeat (2) @(posedge clock_i);
    #1;
    chk({7'h0, irq}, 8'h00);
    $display("test interrupt summary done");
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  initial
  begin
    repeat (6) @(posedge clock_i);
    rst_n_i <= 1'b1;
    t_reset();
    t_gain();
    t_cal();
    t_events();
    t_sign();
    t_irq();
    wrap_up();
  end
  initial
  begin
    #1000000;
    error_cnt++;
    wrap_up();
  end
endmodule
